/* File: hw/level_duration_regs.svh */
// timing and field constants for the level duration measurement block
// assumes a 10 MHz system clock; included by its bare name
`ifndef LEVEL_DURATION_REGS_SVH
`define LEVEL_DURATION_REGS_SVH
`define CLOCK_PERIOD_NS 100
`define TICK_PERIOD_NS 2000
`define TICK_CYCLES (`TICK_PERIOD_NS / `CLOCK_PERIOD_NS)
`define SETUP_TIME_US 214
`define SETUP_CYCLES ((`SETUP_TIME_US * 1000) / `CLOCK_PERIOD_NS)
`define PIN_COUNT 16
`define RESULT_RESET 16'h0000
`define RESULT_ALREADY_OUT 16'h0001
`define RESULT_OVERFLOW 16'h0000
`define COUNT_MAX 16'hFFFF
`endif

/* File: hw/level_duration_pkg.sv */
// types shared by the level duration measurement block
// assumes nothing beyond the standard language
package level_duration_pkg;
   // one-hot measurement sequencer states
   typedef enum logic [3:0]
   {
      st_idle = 4'h1,
      st_setup = 4'h2,
      st_first = 4'h4,
      st_count = 4'h8
   } measure_state_t;
endpackage

/* File: hw/tick_prescaler.sv */
// prescaler producing a one-cycle tick every period cycles
// assumes it is restarted by the sequencer when counting begins
`timescale 1ns/1ps
module tick_prescaler
   import level_duration_pkg::*;
#(
   parameter int period = 20
)
(
   input wire logic clock,
   input wire logic rst_b,
   input wire logic restart,
   output logic tick
);
   localparam int cw = $clog2(period);
   typedef struct packed
   {
      logic [cw-1:0] count; // cycles since last tick
      logic tick;           // registered tick pulse
   } presc_state_t;
   presc_state_t state;
   presc_state_t next_state;

   // a period below two cannot give a single-cycle pulse
   if (period < 2)
   begin : g_bad_period
      $error("tick_prescaler period must be at least 2");
   end

   // next value: count up, wrap and pulse at period
   always_comb
   begin
      next_state = state;
      next_state.tick = 1'b0;
      if (restart)
      begin
         next_state.count = '0;
      end
      else if (state.count == cw'(period - 1))
      begin
         next_state.count = '0;
         next_state.tick = 1'b1;
      end
      else
      begin
         next_state.count = state.count + cw'(1);
      end
   end

   // register the state
   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         state <= '0;
      end
      else
      begin
         state <= next_state;
      end
   end

   assign tick = state.tick;
endmodule // tick_prescaler

/* File: hw/level_duration_measure.sv */
// level duration measurement: times how long a chosen pin holds a level
// assumes 10 MHz clock, pins asynchronous to it, one command at a time
`timescale 1ns/1ps
`include "level_duration_regs.svh"
module level_duration_measure
   import level_duration_pkg::*;
#(
   parameter int pins = `PIN_COUNT,
   parameter int setup_cycles = `SETUP_CYCLES,
   parameter int tick_cycles = `TICK_CYCLES
)
(
   input wire logic clock,
   input wire logic rst_b,
   input wire logic start,
   input wire logic [3:0] pin_select,
   input wire logic watch_level,
   input wire logic [15:0] pin_in,
   output logic [15:0] pin_dir_input,
   output logic busy,
   output logic done,
   output logic [15:0] duration_result
);
   // setup countdown width, wide enough to load setup_cycles itself
   localparam int sw = $clog2(setup_cycles + 1);
   // limitation: a level held past the last count reads 0; the shortest
   // real result is 1, so 0 means overflow, or no result yet since reset

   // whole state in one record; one comb block fills next_state,
   // one clocked block registers it, so no field has two drivers
   typedef struct packed
   {
      logic [15:0] sync1;        // first synchroniser stage
      logic [15:0] sync2;        // second synchroniser stage
      measure_state_t fsm;       // sequencer
      logic [3:0] sel;           // latched pin selector
      logic level;               // latched level argument
      logic [sw-1:0] setup_left; // setup countdown
      logic [15:0] count;        // duration counter
      logic [15:0] dir_input;    // per-pin input direction flags
      logic busy;                // measurement in progress
      logic done;                // result valid pulse
      logic [15:0] result;       // last result
   } meas_state_t;
   // power-up record: sequencer idle, every pin an input, result cleared
   localparam meas_state_t state_reset = '{
      fsm: st_idle,
      dir_input: 16'hFFFF,
      result: `RESULT_RESET,
      default: '0
   };
   meas_state_t state;
   meas_state_t next_state;
   logic tick;                   // 2 us tick from prescaler
   logic in_level;               // watched pin still at level

   // close a measurement: publish the value, pulse done, drop busy
   function automatic meas_state_t close_measure(input meas_state_t s, input logic [15:0] value);
      meas_state_t r;
      r = s;
      r.result = value;
      r.done = 1'b1;
      r.busy = 1'b0;
      r.fsm = st_idle;
      return r;
   endfunction

   // refuse parameter values the logic cannot serve
   if (pins != `PIN_COUNT)
   begin : g_bad_pins
      $error("level_duration_measure serves sixteen pins only");
   end
   if (setup_cycles < 1)
   begin : g_bad_setup
      $error("level_duration_measure needs at least one setup cycle");
   end
   if (tick_cycles < 2)
   begin : g_bad_tick
      $error("level_duration_measure needs a tick of two cycles or more");
   end

   // tick restarts on entering timing so the first cycle is whole
   // restart is held through idle and setup
   tick_prescaler #(
      .period(tick_cycles)
   ) u_tick (
      .clock(clock),
      .rst_b(rst_b),
      .restart(state.fsm != st_first && state.fsm != st_count),
      .tick(tick)
   );

   // compare only the second synchroniser stage
   // the first stage may still be settling from a metastable sample
   assign in_level = (state.sync2[state.sel] == state.level);

   // one measurement, edge by edge:
   // - the edge that takes start latches pin, level and raises busy
   // - setup_cycles edges of setup pass before any tick is counted
   // - the prescaler leaves restart as timing begins, so ticks are whole
   // - the pin is judged through two flops, two cycles after it moves;
   //   a change inside that lag is seen at the following tick
   // - a start while busy is dropped with no indication
   // - the result and the done pulse leave on the same edge busy falls
   // next state of the sequencer and counter
   always_comb
   begin
      next_state = state;
      next_state.sync1 = pin_in;
      next_state.sync2 = state.sync1;
      next_state.done = 1'b0;
      unique case (state.fsm)
         st_idle:
         begin
            // new command only accepted when idle
            if (start)
            begin
               next_state.sel = pin_select;
               next_state.level = watch_level;
               next_state.dir_input[pin_select] = 1'b1;
               next_state.setup_left = sw'(setup_cycles);
               // busy rises on the edge that takes start
               next_state.busy = 1'b1;
               next_state.fsm = st_setup;
            end
         end
         st_setup:
         begin
            // setup latency, excluded from the count
            // the prescaler is held in restart throughout
            if (state.setup_left == sw'(1))
            begin
               next_state.count = 16'h0000;
               next_state.fsm = st_first;
            end
            else
            begin
               next_state.setup_left = state.setup_left - sw'(1);
            end
         end
         st_first:
         begin
            // first timing cycle detects an already changed pin
            if (tick)
            begin
               if (!in_level)
               begin
                  // off level at the first tick: it took one tick to see
                  next_state = close_measure(next_state, `RESULT_ALREADY_OUT);
               end
               else
               begin
                  // still at level: first whole tick counted
                  next_state.count = 16'h0001;
                  next_state.fsm = st_count;
               end
            end
         end
         st_count:
         begin
            // count whole ticks until the level is left or the count overflows
            if (tick)
            begin
               if (!in_level)
               begin
                  // level left: whole ticks spent at level
                  next_state = close_measure(next_state, state.count);
               end
               else if (state.count == `COUNT_MAX)
               begin
                  // held past the last count
                  next_state = close_measure(next_state, `RESULT_OVERFLOW);
               end
               else
               begin
                  // still at level: one more whole tick
                  next_state.count = state.count + 16'h0001;
               end
            end
         end
         default:
         begin
            // illegal code: recover to idle
            next_state.fsm = st_idle;
            next_state.busy = 1'b0;
         end
      endcase
   end

   // register the state; pins power up as inputs
   // reset loads only constants, so release timing cannot matter
   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         // pins come up as inputs; the block never drives a pin out
         state <= state_reset;
      end
      else
      begin
         // normal update from the comb block
         state <= next_state;
      end
   end

   // every output straight from the state record
   assign pin_dir_input = state.dir_input;
   assign busy = state.busy;
   assign done = state.done;
   assign duration_result = state.result;
endmodule // level_duration_measure

/* File: bench/level_duration_checker.sv */
// checker for the level duration block, sees only its ports
// assumes one clock and the async active-low reset of the block
`timescale 1ns/1ps
module level_duration_checker
   import level_duration_pkg::*;
#(
   parameter int pins = 16,
   parameter int setup_cycles = 2140,
   parameter int tick_cycles = 20
)
(
   input wire logic clock,
   input wire logic rst_b,
   input wire logic start,
   input wire logic [3:0] pin_select,
   input wire logic watch_level,
   input wire logic [15:0] pin_in,
   input wire logic [15:0] pin_dir_input,
   input wire logic busy,
   input wire logic done,
   input wire logic [15:0] duration_result
);
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_b);
   property p_dir_set; start && !busy |=> pin_dir_input[$past(pin_select)]; endproperty
   a_dir_set: assert property (p_dir_set) else $error("watched pin not input");
   property p_dir_keep; (~pin_dir_input & $past(pin_dir_input)) == 16'h0000; endproperty
   a_dir_keep: assert property (p_dir_keep) else $error("pin left input mode");
   property p_taken; start && !busy |=> busy && !done; endproperty
   a_taken: assert property (p_taken) else $error("start not taken");
   // busy must hold for five cycles from its rise before any answer
   property p_setup; $rose(busy) |-> busy[*5]; endproperty
   a_setup: assert property (p_setup) else $error("answer inside setup");
   property p_refuse; busy |=> $stable(pin_dir_input); endproperty
   a_refuse: assert property (p_refuse) else $error("start taken while busy");
   property p_done_pulse; done |=> !done; endproperty
   a_done_pulse: assert property (p_done_pulse) else $error("done longer than one");
   property p_done_end; done |-> !busy && $past(busy); endproperty
   a_done_end: assert property (p_done_end) else $error("done without busy end");
   property p_hold; !done |-> $stable(duration_result); endproperty
   a_hold: assert property (p_hold) else $error("result moved without done");
endmodule // level_duration_checker
bind level_duration_measure level_duration_checker #(.pins(pins),
   .setup_cycles(setup_cycles), .tick_cycles(tick_cycles)) i_chk (.clock(clock),
   .rst_b(rst_b), .start(start), .pin_select(pin_select), .watch_level(watch_level),
   .pin_in(pin_in), .pin_dir_input(pin_dir_input), .busy(busy), .done(done),
   .duration_result(duration_result));

/* File: bench/rc_net_model.sv */
// behavioural rc network: watched pin holds level for hold cycles
// assumes start is taken on the same edges the block takes it
`timescale 1ns/1ps
module rc_net_model
(
   input wire logic clock,
   input wire logic start,
   input wire logic busy,
   input wire logic [3:0] pin_select,
   input wire logic watch_level,
   input wire logic [31:0] hold,
   output logic [15:0] pin_in
);
   int left = 0; // cycles the cap still holds the level
   logic [3:0] sel = 4'h0;
   logic lvl = 1'b0;
   logic armed;
   logic [3:0] ws;
   logic lv;
   logic hi;
   // capture the command, then let the cap drain
   always @(posedge clock)
      if (start && !busy)
      begin
         sel <= pin_select;
         lvl <= watch_level;
         left <= hold;
      end
      else if (left > 0)
         left <= left - 1;
   // idle: precharged when hold is nonzero; other pins sit off level
   always_comb
   begin
      armed = busy || left > 0;
      ws = armed ? sel : pin_select;
      lv = armed ? lvl : watch_level;
      hi = armed ? left > 0 : hold != 0;
      pin_in = {16{~lv}} ^ ({15'h0000, hi} << ws);
   end
endmodule // rc_net_model

/* File: bench/tb.sv */
// self-checking bench for the level duration block
// assumes short setup (4) and 20-cycle tick so runs stay brief
`timescale 1ns/1ps
module tb;
   logic clock = 0;
   logic rst_b = 0;
   logic start = 0;
   logic watch_level = 0;
   logic [3:0] pin_select = 4'h0;
   int hold = 0;
   logic [15:0] pin_in;
   logic [15:0] pin_dir_input;
   logic [15:0] duration_result;
   logic busy;
   logic done;
   int n_errors = 0;
   int checks = 0;
   always #50 clock = ~clock;
   level_duration_measure #(.setup_cycles(4), .tick_cycles(20)) i_dut (.clock(clock),
      .rst_b(rst_b), .start(start), .pin_select(pin_select), .watch_level(watch_level),
      .pin_in(pin_in), .pin_dir_input(pin_dir_input), .busy(busy), .done(done),
      .duration_result(duration_result));
   rc_net_model i_rc (.clock(clock), .start(start), .busy(busy), .pin_select(pin_select),
      .watch_level(watch_level), .hold(hold), .pin_in(pin_in));
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      checks++;
      if (got !== exp)
      begin
         n_errors++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic conclude;
      $display("checks %0d errors %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // release mid-tick so the sync lag cannot shift the count
   task automatic measure(input logic [3:0] p, input logic l, input int n, input bit poke);
      int t;
      @(posedge clock);
      pin_select <= p;
      watch_level <= l;
      hold <= (n == 0) ? 0 : 20 * n + 15;
      repeat (3) @(posedge clock);
      start <= 1;
      @(posedge clock);
      start <= 0;
      if (poke)
      begin
         @(posedge clock);
         start <= 1;
         pin_select <= p + 4'h1;
         @(posedge clock);
         start <= 0;
      end
      t = 0;
      @(negedge clock);
      while (done !== 1'b1 && t < 3000)
      begin
         @(negedge clock);
         t++;
      end
      chk("done", 16'h0001, {15'h0000, done});
      chk("result", (n == 0) ? 16'h0001 : 16'(n), duration_result);
      chk("pin input", 16'h0001, {15'h0000, pin_dir_input[p]});
   endtask
   task automatic test_reset;
      @(negedge clock);
      chk("reset dir", 16'hFFFF, pin_dir_input);
      chk("reset busy", 16'h0000, {15'h0000, busy});
      chk("reset result", 16'h0000, duration_result);
      $display("test_reset done");
   endtask
   task automatic test_levels;
      for (int i = 0; i < 6; i++)
         measure(4'(i * 3), i[0], i * 7 + 1, 0);
      $display("test_levels done");
   endtask
   task automatic test_already;
      measure(4'h4, 1'b1, 0, 0);
      measure(4'h9, 1'b0, 0, 0);
      $display("test_already done");
   endtask
   task automatic test_refuse;
      measure(4'hA, 1'b1, 3, 1);
      $display("test_refuse done");
   endtask
   initial
   begin
      repeat (10) @(posedge clock);
      rst_b <= 1;
      test_reset();
      test_levels();
      test_already();
      test_refuse();
      conclude();
   end
   // tests need well under 10000 cycles
   initial
   begin
      #(100 * 30000);
      n_errors++;
      conclude();
   end
endmodule // tb
